//--- psau_pkg.sv
/*
 * Package for the program space access unit: register offsets, reset values,
 * field positions, table operation codes and address layout constants.
 * Assumes a classic Wishbone slave with 32-bit data and byte addresses.
 */
// Functional notes
// R01 - Table accesses form a 24-bit program address as table page above the 16-bit effective address.
// R02 - Each table page spans a 32K word region and its bit 7 picks configuration (1) or user (0) memory.
// R03 - A data address with its top bit set maps to remap page followed by its low 15 bits, a 23-bit address.
// R04 - Remapped accesses always land in user memory, never configuration memory.
// R05 - The remap window is read-only and returns only the low 16-bit word of each program word.
// R06 - Program addresses step by two per 24-bit word, giving a low word space and an upper byte space.
// R07 - A word-mode low table read returns program bits 15 to 0 unchanged.
// R08 - A byte-mode low table read returns the upper low-word byte when byte select is 1, else the lower byte.
// R09 - A word-mode high table read returns program bits 23 to 16 with data bits 15 to 8 at zero.
// R10 - A byte-mode high table read returns the selected byte on bits 7 to 0, zero for the phantom byte.
// R11 - Only the high table operations reach the upper 8 bits of a program word.
// R12 - Configuration space takes only table reads, in implemented areas; table writes there are dropped.
// R13 - Data EEPROM is reached only by low table operations; software keeps high operations off it.
// R14 - Both table reads support byte and word transfers.
// R15 - The byte select is the least significant bit of the data effective address.
// R16 - Table writes to user memory go to the flash programming logic with address and data only; the code also hands on the high and byte flags.
package psau_pkg;

    // Register byte offsets
    localparam logic [3:0] TABLE_PAGE_OFFSET  = 4'h0;
    localparam logic [3:0] REMAP_PAGE_OFFSET  = 4'h4;
    localparam logic [3:0] STATUS_OFFSET      = 4'h8;

    // Reset values
    localparam logic [7:0] TABLE_PAGE_RESET   = 8'h00;
    localparam logic [7:0] REMAP_PAGE_RESET   = 8'h00;

    // Field positions
    localparam int         CONFIG_SEL_BIT     = 7;
    localparam int         ADDR_TOP_BIT       = 15;
    localparam int         BYTE_SEL_BIT       = 0;

    // Status register bit positions
    localparam int         ST_BUSY_BIT        = 0;
    localparam int         ST_CFG_BIT         = 1;
    localparam int         ST_DROP_BIT        = 2;

    // Table operation codes
    localparam logic [1:0] OP_READ_LOW        = 2'h0;
    localparam logic [1:0] OP_READ_HIGH       = 2'h1;
    localparam logic [1:0] OP_WRITE_LOW       = 2'h2;
    localparam logic [1:0] OP_WRITE_HIGH      = 2'h3;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_DONE = 3'b100
    } psau_state_t;

endpackage : psau_pkg

//--- program_space_access_unit.sv
/*
 * Program space access unit: table reads and writes into 24-bit program
 * memory, and a read-only remap window in the upper half of data space.
 * Assumes program memory answers a read with mem_rvalid_i some cycles after
 * a one-cycle mem_rd_o pulse, and that the CPU raises one request at a time.
 */
// Design decisions made here: register access over Wishbone and the address map.
`timescale 1ns/1ps
`default_nettype none

module program_space_access_unit
    import psau_pkg::*;
(
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        ce_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // CPU table operations
    input  wire logic        table_req_i,
    input  wire logic [1:0]  table_op_i,
    input  wire logic        table_byte_i,
    input  wire logic [15:0] effective_address_i,
    input  wire logic [15:0] table_wdata_i,
    // CPU data reads through the remap window
    input  wire logic        remap_req_i,
    input  wire logic [15:0] remap_address_i,
    output logic             cpu_done_o,
    output logic      [15:0] cpu_rdata_o,
    // Program memory read port
    output logic             mem_rd_o,
    output logic      [23:0] mem_addr_o,
    output logic             mem_high_o,
    input  wire logic        mem_rvalid_i,
    input  wire logic [23:0] mem_rdata_i,
    // Flash programming logic write hand-off
    output logic             flash_wr_o,
    output logic      [23:0] flash_addr_o,
    output logic             flash_high_o,
    output logic             flash_byte_o,
    output logic      [15:0] flash_wdata_o
);

    // ******************************************************************
    // Register file
    // ******************************************************************
    logic [7:0]  table_page_reg;
    logic [7:0]  remap_page_reg;
    logic        drop_reg;
    logic        wb_hit;
    psau_state_t state_reg;

    assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

    // Only byte lane 0 carries page bits; the upper lanes are ignored
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            table_page_reg <= TABLE_PAGE_RESET;
            remap_page_reg <= REMAP_PAGE_RESET;
        end
        else if (ce_i && wb_hit && wb_we_i && wb_sel_i[0])
        begin
            if (wb_adr_i == TABLE_PAGE_OFFSET)
                table_page_reg <= wb_dat_i[7:0];
            if (wb_adr_i == REMAP_PAGE_OFFSET)
                remap_page_reg <= wb_dat_i[7:0];
        end
    end

    // Unmapped offsets read zero and still ack, so a stray access never hangs
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce_i)
        begin
            wb_ack_o <= wb_hit;
            wb_dat_o <= 32'h0000_0000;
            if (wb_hit && !wb_we_i)
            begin
                case (wb_adr_i)
                    TABLE_PAGE_OFFSET: wb_dat_o <= {24'h000000, table_page_reg};
                    REMAP_PAGE_OFFSET: wb_dat_o <= {24'h000000, remap_page_reg};
                    STATUS_OFFSET:
                    begin
                        wb_dat_o[ST_BUSY_BIT] <= (state_reg != ST_IDLE);
                        wb_dat_o[ST_CFG_BIT]  <= table_page_reg[CONFIG_SEL_BIT];
                        wb_dat_o[ST_DROP_BIT] <= drop_reg;
                    end
                    default: wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ******************************************************************
    // Address formation
    // ******************************************************************
    logic [23:0] table_addr;
    logic [23:0] remap_addr;
    logic        is_config;
    logic        is_high_op;
    logic        is_write_op;

    assign table_addr  = {table_page_reg, effective_address_i}; // R01 R02 R06
    // Bit 23 forced low keeps the window out of configuration memory
    assign remap_addr  = {1'b0, remap_page_reg, remap_address_i[ADDR_TOP_BIT-1:0]}; // R03 R04
    assign is_config   = table_page_reg[CONFIG_SEL_BIT]; // R02
    assign is_high_op  = (table_op_i == OP_READ_HIGH) || (table_op_i == OP_WRITE_HIGH); // R11
    assign is_write_op = (table_op_i == OP_WRITE_LOW) || (table_op_i == OP_WRITE_HIGH);

    // ******************************************************************
    // Request sequencing
    // ******************************************************************
    logic [1:0]  op_reg;
    logic        byte_reg;
    logic        bsel_reg;
    logic        remap_reg;
    logic        table_go;
    logic        table_read_go;
    logic        table_write_go;
    logic        remap_go;

    // Table requests win over the window when both arrive together
    assign table_go       = (state_reg == ST_IDLE) && table_req_i;
    assign table_read_go  = table_go && !is_write_op;
    assign table_write_go = table_go && is_write_op;
    assign remap_go       = (state_reg == ST_IDLE) && !table_req_i && remap_req_i && remap_address_i[ADDR_TOP_BIT]; // R03

    // Requests seen while busy are ignored; the core holds its request until done
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            state_reg <= ST_IDLE;
        else if (ce_i)
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    // Configuration space writes are dropped, but still completed
                    if (table_write_go)
                        state_reg <= ST_DONE;
                    else if (table_read_go || remap_go)
                        state_reg <= ST_WAIT;
                end
                ST_WAIT:
                begin
                    if (mem_rvalid_i)
                        state_reg <= ST_DONE;
                end
                ST_DONE:
                    state_reg <= ST_IDLE;
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Request attributes steer the read data once memory answers
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            op_reg    <= OP_READ_LOW;
            byte_reg  <= 1'b0;
            bsel_reg  <= 1'b0;
            remap_reg <= 1'b0;
        end
        else if (ce_i && table_go)
        begin
            op_reg    <= table_op_i;
            byte_reg  <= table_byte_i; // R14
            bsel_reg  <= effective_address_i[BYTE_SEL_BIT]; // R15
            remap_reg <= 1'b0;
        end
        else if (ce_i && remap_go)
        begin
            // The window has no write path at all
            op_reg    <= OP_READ_LOW;
            byte_reg  <= 1'b0;
            bsel_reg  <= 1'b0;
            remap_reg <= 1'b1; // R05
        end
    end

    // The strobe lasts one cycle; address and lane stand until the next read
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            mem_rd_o   <= 1'b0;
            mem_addr_o <= 24'h000000;
            mem_high_o <= 1'b0;
        end
        else if (ce_i)
        begin
            mem_rd_o <= table_read_go || remap_go;
            if (table_read_go)
            begin
                mem_addr_o <= table_addr;
                mem_high_o <= is_high_op; // R13
            end
            else if (remap_go)
            begin
                mem_addr_o <= remap_addr;
                mem_high_o <= 1'b0; // R05
            end
        end
    end

    // Address, data and the high and byte flags are handed on; latching and commit belong to the flash logic
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            flash_wr_o    <= 1'b0;
            flash_addr_o  <= 24'h000000;
            flash_high_o  <= 1'b0;
            flash_byte_o  <= 1'b0;
            flash_wdata_o <= 16'h0000;
        end
        else if (ce_i)
        begin
            flash_wr_o <= table_write_go && !is_config; // R16
            if (table_write_go && !is_config)
            begin
                flash_addr_o  <= table_addr;
                flash_high_o  <= is_high_op;
                flash_byte_o  <= table_byte_i;
                flash_wdata_o <= table_wdata_i;
            end
        end
    end

    // Sticky until reset, so software can still see a refused configuration write
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            drop_reg <= 1'b0;
        else if (ce_i && table_write_go && is_config)
            drop_reg <= 1'b1; // R12
    end

    // ******************************************************************
    // Read data steering
    // ******************************************************************
    // Steering uses the captured request, so memory may answer in any later cycle
    logic [15:0] steer_data;

    always_comb
    begin
        steer_data = 16'h0000;
        if (op_reg == OP_READ_HIGH)
        begin
            if (!byte_reg)
                steer_data = {8'h00, mem_rdata_i[23:16]}; // R09
            else if (!bsel_reg)
                steer_data = {8'h00, mem_rdata_i[23:16]}; // R10
            else
                steer_data = 16'h0000; // R10
        end
        else if (remap_reg || !byte_reg)
            steer_data = mem_rdata_i[15:0]; // R05 R07
        else if (bsel_reg)
            steer_data = {8'h00, mem_rdata_i[15:8]}; // R08
        else
            steer_data = {8'h00, mem_rdata_i[7:0]}; // R08
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            cpu_done_o  <= 1'b0;
            cpu_rdata_o <= 16'h0000;
        end
        else if (ce_i)
        begin
            cpu_done_o <= 1'b0;
            // Writes complete the cycle after they are taken, reads once memory answers
            if (state_reg == ST_WAIT && mem_rvalid_i)
            begin
                cpu_done_o  <= 1'b1;
                cpu_rdata_o <= steer_data;
            end
            else if (state_reg == ST_IDLE && table_req_i && is_write_op)
                cpu_done_o <= 1'b1;
        end
    end

endmodule : program_space_access_unit

`default_nettype wire

//--- psau_mem.sv
/* Program memory model for the access unit.
   Assumes one read at a time, started by a one-cycle rd_i pulse. */
`timescale 1ns/1ps
`default_nettype none
module psau_mem (
    input  wire logic        clk_i,
    input  wire logic        slow_i,
    input  wire logic        rd_i,
    input  wire logic [23:0] addr_i,
    output logic             rvalid_o = 1'h0,
    output logic      [23:0] rdata_o = 24'h0
);
    logic       busy_reg = 1'h0;
    logic [2:0] cnt_reg  = 3'h0;
    logic [23:0] a_reg   = 24'h0;
    // ************
    // Read answer
    // ************
    // Idle data flips each cycle so stale words are never mistaken for valid
    always_ff @(posedge clk_i)
    begin
        rvalid_o <= 1'h0;
        rdata_o  <= ~rdata_o;
        if (rd_i)
        begin
            busy_reg <= 1'h1;
            a_reg    <= addr_i;
            cnt_reg  <= slow_i ? 3'h4 : 3'h0;
        end
        else if (busy_reg && cnt_reg != 3'h0)
            cnt_reg <= cnt_reg - 3'h1;
        else if (busy_reg)
        begin
            busy_reg <= 1'h0;
            rvalid_o <= 1'h1;
            rdata_o  <= {a_reg[7:0] ^ 8'hC3, a_reg[15:0] ^ 16'h5A3C};
        end
    end
endmodule : psau_mem
`default_nettype wire

//--- psau_props.sv
/* Port checker for the access unit.
   Assumes bind by name onto the unit's ports. */
`timescale 1ns/1ps
`default_nettype none
module psau_props (
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        ce_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o,
    input wire logic        table_req_i,
    input wire logic        table_byte_i,
    input wire logic [15:0] effective_address_i,
    input wire logic        remap_req_i,
    input wire logic [15:0] remap_address_i,
    input wire logic        cpu_done_o,
    input wire logic [15:0] cpu_rdata_o,
    input wire logic        mem_rd_o,
    input wire logic [23:0] mem_addr_o,
    input wire logic        mem_high_o,
    input wire logic        mem_rvalid_i,
    input wire logic [23:0] mem_rdata_i,
    input wire logic        flash_wr_o,
    input wire logic [23:0] flash_addr_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o) else $error("ack late");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack stuck");
    a_tbl_addr: assert property (mem_rd_o && $past(table_req_i)
        |-> mem_addr_o[15:0] == $past(effective_address_i)) else $error("table address");
    a_remap_user: assert property (mem_rd_o && $past(remap_req_i && !table_req_i)
        |-> !mem_addr_o[23] && mem_addr_o[14:0] == $past(remap_address_i[14:0])) else $error("remap address");
    a_remap_low: assert property (mem_rd_o && $past(remap_req_i && !table_req_i) |-> !mem_high_o)
        else $error("remap high");
    a_cfg_nowr: assert property (flash_wr_o |-> !flash_addr_o[23]) else $error("config write");
    a_wr_done: assert property (flash_wr_o |-> cpu_done_o) else $error("write done");
    a_high_zero: assert property (cpu_done_o && $past(mem_rvalid_i) && mem_high_o
        |-> cpu_rdata_o[15:8] == 8'h00) else $error("phantom byte");
    a_low_word: assert property (cpu_done_o && $past(mem_rvalid_i) && !mem_high_o && !$past(table_byte_i)
        |-> cpu_rdata_o == $past(mem_rdata_i[15:0])) else $error("low word");
    a_done_lat: assert property (mem_rvalid_i && ce_i |=> cpu_done_o) else $error("done late");
endmodule : psau_props
`default_nettype wire

//--- program_space_access_unit_tb.sv
/* Testbench for the program space access unit.
   Assumes psau_mem as program memory and psau_props as checker. */
`timescale 1ns/1ps
`default_nettype none
module program_space_access_unit_tb
    import psau_pkg::*;
;
    logic clk_i = 0, rst_i = 1, ce_i = 1, slow = 0;
    logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
    logic [3:0] wb_adr_i = 4'h0, wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
    logic table_req_i = 0, table_byte_i = 0, remap_req_i = 0;
    logic [1:0] table_op_i = 2'h0;
    logic [15:0] effective_address_i = 0, table_wdata_i = 0, remap_address_i = 0, cpu_rdata_o, flash_wdata_o;
    logic cpu_done_o, mem_rd_o, mem_high_o, mem_rvalid_i, flash_wr_o, flash_high_o, flash_byte_o;
    logic [23:0] mem_addr_o, mem_rdata_i, flash_addr_o, ad, p;
    int error_cnt = 0, n_tests = 0, cyc = 0, fw = 0, nrd = 0;
    always #5 clk_i = ~clk_i;
    program_space_access_unit uut (.*);
    psau_mem mem_i (.clk_i, .slow_i(slow), .rd_i(mem_rd_o), .addr_i(mem_addr_o),
        .rvalid_o(mem_rvalid_i), .rdata_o(mem_rdata_i));
    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        fw  <= fw + flash_wr_o;
        nrd <= nrd + mem_rd_o;
        if (cyc == 5000)
        begin
            error_cnt++;
            test_done();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_i);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'h3, we, a, d};
        do @(posedge clk_i); while (wb_ack_o !== 1'h1);
        q = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'h0;
    endtask : wb
    task automatic op(input logic rm, input logic [1:0] o, input logic b, input logic [15:0] a);
        @(posedge clk_i);
        {table_op_i, table_byte_i, effective_address_i, remap_address_i} <= {o, b, a, a};
        {remap_req_i, table_req_i} <= {rm, !rm};
        do
        begin
            @(posedge clk_i);
            if (mem_rd_o === 1'h1) ad = mem_addr_o;
        end while (cpu_done_o !== 1'h1);
        {remap_req_i, table_req_i} <= 2'h0;
        repeat (2) @(posedge clk_i);
    endtask : op
    task automatic s_regs;
        wb(0, TABLE_PAGE_OFFSET, 0);
        chk(q, {24'h0, TABLE_PAGE_RESET});
        wb(0, REMAP_PAGE_OFFSET, 0);
        chk(q, {24'h0, REMAP_PAGE_RESET});
        wb(1, TABLE_PAGE_OFFSET, 32'h12);
        wb(1, REMAP_PAGE_OFFSET, 32'h35);
        wb(1, 4'hC, 32'hFF);
        wb(0, 4'hC, 0);
        chk(q, 32'h0);
        wb(0, TABLE_PAGE_OFFSET, 0);
        chk(q, 32'h12);
    endtask : s_regs
    task automatic s_reads;
        logic [15:0] e;
        for (int i = 0; i < 8; i++)
        begin
            slow <= i[0];
            op(0, i[2] ? OP_READ_HIGH : OP_READ_LOW, i[1], 16'h2468 | i[0]);
            chk(ad, {8'h12, 16'h2468 | i[0]});
            p = {ad[7:0] ^ 8'hC3, ad[15:0] ^ 16'h5A3C};
            e = i[2] ? ((i[1] && i[0]) ? 16'h0 : {8'h0, p[23:16]}) :
                (!i[1] ? p[15:0] : {8'h0, i[0] ? p[15:8] : p[7:0]});
            chk(cpu_rdata_o, e);
        end
    endtask : s_reads
    task automatic s_writes;
        table_wdata_i <= 16'hBEEF;
        op(0, OP_WRITE_LOW, 0, 16'h0A02);
        chk(flash_addr_o, 24'h120A02);
        chk(flash_wdata_o, 16'hBEEF);
        chk({flash_high_o, flash_byte_o}, 2'h0);
        op(0, OP_WRITE_HIGH, 1, 16'h0A04);
        chk(flash_high_o, 1'h1);
        chk(flash_byte_o, 1'h1);
        wb(1, TABLE_PAGE_OFFSET, 32'h81);
        op(0, OP_WRITE_LOW, 0, 16'h0A06);
        chk(fw, 2);
        chk(flash_addr_o, 24'h120A04);
        wb(0, STATUS_OFFSET, 0);
        chk(q, 32'h6);
        op(0, OP_READ_LOW, 0, 16'h0010);
        chk(ad, 24'h810010);
    endtask : s_writes
    task automatic s_remap;
        int x;
        op(1, OP_READ_LOW, 0, 16'h8123);
        chk(ad, {1'h0, 8'h35, 15'h0123});
        chk(cpu_rdata_o, 16'h8123 ^ 16'h5A3C);
        x = nrd;
        remap_address_i <= 16'h0123;
        remap_req_i <= 1'h1;
        repeat (6) @(posedge clk_i);
        remap_req_i <= 1'h0;
        repeat (2) @(posedge clk_i);
        chk(nrd, x);
    endtask : s_remap
    task automatic s_hold;
        int x;
        x = nrd;
        @(posedge clk_i);
        ce_i <= 1'h0;
        {table_op_i, table_byte_i, table_req_i} <= {OP_READ_LOW, 1'h0, 1'h1};
        repeat (4) @(posedge clk_i);
        chk(nrd, x);
        chk(cpu_done_o, 1'h0);
        table_req_i <= 1'h0;
        ce_i <= 1'h1;
        rst_i <= 1'h1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'h0;
        wb(0, STATUS_OFFSET, 0);
        chk(q, 32'h0);
        wb(0, REMAP_PAGE_OFFSET, 0);
        chk(q, {24'h0, REMAP_PAGE_RESET});
    endtask : s_hold
    task automatic test_done;
        if (error_cnt == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : test_done
    initial
    begin
        repeat (4) @(posedge clk_i);
        rst_i <= 1'h0;
        s_regs();
        s_reads();
        s_writes();
        s_remap();
        s_hold();
        test_done();
    end
endmodule : program_space_access_unit_tb
bind program_space_access_unit psau_props props_i (.*);
`default_nettype wire
